// >>> rtl/cps_map.svh
`ifndef CPS_MAP_SVH
`define CPS_MAP_SVH
// times in microseconds, counts derived at 100 MHz (100 cycles per us)
`define CPS_CLK_MHZ 100
`define CPS_POR_BLANK_US 8000
`define CPS_OVP_RETRY_US 8000
`define CPS_BOVP_BLANK_US 176
`define CPS_OVP_RESP_US 1
`define CPS_OCP_BLANK_US 100
`define CPS_OCP_RETRY_US 1000
`define CPS_POR_DEGLITCH_US 10
`define CPS_POR_BLANK_CYC (`CPS_POR_BLANK_US * `CPS_CLK_MHZ)
`define CPS_OVP_RETRY_CYC (`CPS_OVP_RETRY_US * `CPS_CLK_MHZ)
`define CPS_BOVP_BLANK_CYC (`CPS_BOVP_BLANK_US * `CPS_CLK_MHZ)
`define CPS_OVP_RESP_CYC (`CPS_OVP_RESP_US * `CPS_CLK_MHZ)
`define CPS_OCP_BLANK_CYC (`CPS_OCP_BLANK_US * `CPS_CLK_MHZ)
`define CPS_OCP_RETRY_CYC (`CPS_OCP_RETRY_US * `CPS_CLK_MHZ)
`define CPS_POR_DEGLITCH_CYC (`CPS_POR_DEGLITCH_US * `CPS_CLK_MHZ)
`define CPS_LATCH_COUNT 16
`define CPS_TMR_W 24
`define CPS_CNT_W 5
`endif

// >>> rtl/cps_pkg.sv
package cps_pkg;
    typedef struct packed {
        logic supply_ok;
        logic input_surge;
        logic overcurrent;
        logic cell_surge;
        logic over_temp;
        logic limit_open;
        logic reverse_ok;
    } cps_flags_t;

    typedef enum logic [2:0] {
        CPS_OFF = 3'b000,
        CPS_BLANK = 3'b001,
        CPS_ON = 3'b010,
        CPS_SURGE_WAIT = 3'b011,
        CPS_OC_RETRY = 3'b100,
        CPS_CELL_OFF = 3'b101,
        CPS_LATCHED = 3'b110
    } cps_state_t;
endpackage

// >>> rtl/cps_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "cps_map.svh"
// counts while run is high; done once count reaches limit; clears when run drops
module cps_timer (
    input wire logic clk,
    input wire logic rst,
    input wire logic run,
    input wire logic [`CPS_TMR_W-1:0] limit,
    output logic done
);
    logic [`CPS_TMR_W-1:0] cnt_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
        end else if (!run) begin
            cnt_q <= '0;
        end else if (cnt_q != limit) begin
            cnt_q <= cnt_q + `CPS_TMR_W'(1);
        end
    end

    assign done = run && (cnt_q == limit);
endmodule
`default_nettype wire

// >>> rtl/cps_deglitch.sv
`timescale 1ns/1ps
`default_nettype none
`include "cps_map.svh"
// level follows raw only after raw has held its new value for the full window
module cps_deglitch (
    input wire logic clk,
    input wire logic rst,
    input wire logic raw,
    output logic level
);
    logic level_q;
    logic differ;
    logic held;

    assign differ = raw != level_q;

    cps_timer u_tmr (
        .clk(clk),
        .rst(rst),
        .run(differ),
        .limit(`CPS_TMR_W'(`CPS_POR_DEGLITCH_CYC)),
        .done(held)
    );

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            level_q <= 1'b0;
        end else if (held) begin
            level_q <= raw;
        end
    end

    assign level = level_q;
endmodule
`default_nettype wire

// >>> rtl/cps_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "cps_map.svh"
module cps_sequencer (
    input wire logic clk,
    input wire logic rst,
    input wire logic supply_input_ok,
    input wire logic input_surge,
    input wire logic overcurrent,
    input wire logic cell_surge,
    input wire logic over_temp,
    input wire logic current_limit_open,
    input wire logic reverse_sense,
    input wire logic enable_n,
    output logic pass_gate,
    output logic soft_start,
    output logic current_limit_mode,
    output logic reverse_pass_switch,
    output logic fault_n_oe,
    output logic latched_off
);
    cps_pkg::cps_flags_t flg;
    cps_pkg::cps_state_t state_q;
    cps_pkg::cps_state_t state_d;
    logic supply_ok;
    logic enabled;
    logic en_q;
    logic blank_done, surge_done, ocb_done, ocr_done, cellb_done;
    logic [`CPS_CNT_W-1:0] fault_cnt_q;
    logic latch_q;
    logic count_evt;
    logic gate_q, ss_q, cl_q, rev_q, flt_q;

    // dips on the supply flag shorter than the window never reach the sequence
    cps_deglitch u_por (
        .clk(clk),
        .rst(rst),
        .raw(supply_input_ok),
        .level(supply_ok)
    );

    always_comb begin
        flg.supply_ok = supply_ok;
        flg.input_surge = input_surge;
        flg.overcurrent = overcurrent;
        flg.cell_surge = cell_surge;
        flg.over_temp = over_temp;
        flg.limit_open = current_limit_open;
        flg.reverse_ok = reverse_sense;
    end

    // a floating pin is pulled low on the die, so low means enabled
    assign enabled = !enable_n;

    // reverse flow bypasses every over-current action
    function automatic logic fwd_oc(input cps_pkg::cps_flags_t f);
        return f.overcurrent && !f.reverse_ok;
    endfunction

    cps_timer u_blank (.clk(clk), .rst(rst),
        .run(state_q == cps_pkg::CPS_BLANK),
        .limit(`CPS_TMR_W'(`CPS_POR_BLANK_CYC)), .done(blank_done));
    cps_timer u_surge (.clk(clk), .rst(rst),
        .run(state_q == cps_pkg::CPS_SURGE_WAIT && !flg.input_surge),
        .limit(`CPS_TMR_W'(`CPS_OVP_RETRY_CYC)), .done(surge_done));
    cps_timer u_ocb (.clk(clk), .rst(rst),
        .run(state_q == cps_pkg::CPS_ON && fwd_oc(flg)),
        .limit(`CPS_TMR_W'(`CPS_OCP_BLANK_CYC)), .done(ocb_done));
    cps_timer u_ocr (.clk(clk), .rst(rst),
        .run(state_q == cps_pkg::CPS_OC_RETRY),
        .limit(`CPS_TMR_W'(`CPS_OCP_RETRY_CYC)), .done(ocr_done));
    cps_timer u_cellb (.clk(clk), .rst(rst),
        .run(state_q == cps_pkg::CPS_ON && flg.cell_surge),
        .limit(`CPS_TMR_W'(`CPS_BOVP_BLANK_CYC)), .done(cellb_done));

    // a surge or power loss in the same cycle takes over, so that shutdown is not counted
    assign count_evt = (state_q == cps_pkg::CPS_ON) && flg.supply_ok && !flg.input_surge
        && (ocb_done || cellb_done);

    always_comb begin
        state_d = state_q;
        case (state_q)
            cps_pkg::CPS_OFF: begin
                if (flg.supply_ok) state_d = cps_pkg::CPS_BLANK;
            end
            cps_pkg::CPS_BLANK: begin
                if (blank_done) state_d = cps_pkg::CPS_ON;
            end
            cps_pkg::CPS_ON: begin
                if (flg.input_surge) state_d = cps_pkg::CPS_SURGE_WAIT;
                else if (latch_q) state_d = cps_pkg::CPS_LATCHED;
                else if (ocb_done) state_d = cps_pkg::CPS_OC_RETRY;
                else if (cellb_done) state_d = cps_pkg::CPS_CELL_OFF;
            end
            cps_pkg::CPS_SURGE_WAIT: begin
                if (surge_done) state_d = cps_pkg::CPS_ON;
            end
            cps_pkg::CPS_OC_RETRY: begin
                if (flg.input_surge) state_d = cps_pkg::CPS_SURGE_WAIT;
                else if (ocr_done) state_d = cps_pkg::CPS_ON;
            end
            cps_pkg::CPS_CELL_OFF: begin
                if (flg.input_surge) state_d = cps_pkg::CPS_SURGE_WAIT;
                else if (!flg.cell_surge) state_d = cps_pkg::CPS_ON;
            end
            cps_pkg::CPS_LATCHED: begin
                if (!latch_q) state_d = cps_pkg::CPS_ON;
            end
            default: state_d = cps_pkg::CPS_OFF;
        endcase
        if (!flg.supply_ok) state_d = cps_pkg::CPS_OFF;
        if (latch_q && state_d != cps_pkg::CPS_OFF) state_d = cps_pkg::CPS_LATCHED;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= cps_pkg::CPS_OFF;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            en_q <= 1'b1; // pin idles enabled, so reset leaves no false edge
        end else begin
            en_q <= enabled;
        end
    end

    // the count survives disable; only a fresh enable edge or power loss clears it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fault_cnt_q <= '0;
            latch_q <= 1'b0;
        end else if (count_evt && !latch_q) begin
            // a shutdown meeting the enable edge still counts: the set wins
            fault_cnt_q <= fault_cnt_q + `CPS_CNT_W'(1);
            if (fault_cnt_q == `CPS_CNT_W'(`CPS_LATCH_COUNT - 1)) latch_q <= 1'b1;
        end else if (!flg.supply_ok || (enabled && !en_q)) begin
            fault_cnt_q <= '0;
            latch_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gate_q <= 1'b0;
            ss_q <= 1'b0;
        end else begin
            gate_q <= state_d == cps_pkg::CPS_ON && enabled && !latch_q && !flg.input_surge
                && !flg.over_temp && !flg.limit_open;
            ss_q <= state_q == cps_pkg::CPS_BLANK && blank_done;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cl_q <= 1'b0;
            rev_q <= 1'b0;
            flt_q <= 1'b0;
        end else begin
            cl_q <= state_q == cps_pkg::CPS_ON && fwd_oc(flg);
            rev_q <= flg.reverse_ok;
            flt_q <= flg.input_surge || state_d == cps_pkg::CPS_SURGE_WAIT || fwd_oc(flg)
                || state_d == cps_pkg::CPS_OC_RETRY || state_d == cps_pkg::CPS_CELL_OFF
                || state_d == cps_pkg::CPS_LATCHED;
        end
    end

    assign pass_gate = gate_q;
    assign soft_start = ss_q;
    assign current_limit_mode = cl_q;
    assign reverse_pass_switch = rev_q;
    assign fault_n_oe = flt_q;
    assign latched_off = latch_q;

    // assertion helpers only; nothing in the switching path reads them
    logic [`CPS_TMR_W-1:0] supply_age_q, surge_age_q, oc_age_q, cell_age_q;

    // saturating age, so a long-past event never wraps into a recent one
    function automatic logic [`CPS_TMR_W-1:0] age_next(input logic hold, input logic [`CPS_TMR_W-1:0] age);
        if (!hold) return '0;
        if (age == {`CPS_TMR_W{1'b1}}) return age;
        return age + `CPS_TMR_W'(1);
    endfunction

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            supply_age_q <= '0;
            surge_age_q <= {`CPS_TMR_W{1'b1}};
            oc_age_q <= '0;
            cell_age_q <= '0;
        end else begin
            supply_age_q <= age_next(supply_ok, supply_age_q);
            surge_age_q <= age_next(!input_surge, surge_age_q);
            oc_age_q <= age_next(overcurrent && !reverse_sense, oc_age_q);
            cell_age_q <= age_next(cell_surge, cell_age_q);
        end
    end

    chk_surge_off: assert property (@(posedge clk) disable iff (rst)
        input_surge |=> !pass_gate)
        else $error("gate still on after input surge");
    chk_surge_retry: assert property (@(posedge clk) disable iff (rst)
        $fell(input_surge) |=> !pass_gate [*8])
        else $error("gate returned before surge retry");
    chk_fault_ind: assert property (@(posedge clk) disable iff (rst)
        (input_surge || (overcurrent && !reverse_sense)) |=> fault_n_oe)
        else $error("fault indication missing");
    chk_latch_gate: assert property (@(posedge clk) disable iff (rst)
        latched_off |=> !pass_gate)
        else $error("gate on while latched");
    chk_reverse_nolim: assert property (@(posedge clk) disable iff (rst)
        reverse_sense |=> !current_limit_mode)
        else $error("limit during reverse flow");
    chk_limit_open: assert property (@(posedge clk) disable iff (rst)
        current_limit_open |=> !pass_gate)
        else $error("gate on with open limit pin");
    chk_temp_off: assert property (@(posedge clk) disable iff (rst)
        over_temp |=> !pass_gate)
        else $error("gate on while hot");
    chk_disable_off: assert property (@(posedge clk) disable iff (rst)
        enable_n |=> !pass_gate)
        else $error("gate on while disabled");
    chk_reverse_on: assert property (@(posedge clk) disable iff (rst)
        reverse_sense |=> reverse_pass_switch)
        else $error("reverse switch not on");
    chk_por_blank: assert property (@(posedge clk) disable iff (rst)
        $rose(state_q == cps_pkg::CPS_BLANK) |=> !pass_gate [*8])
        else $error("gate on during blanking");

    // span checks look back through the saturating ages instead of long repetitions
    chk_soft_pulse: assert property (@(posedge clk) disable iff (rst)
        soft_start |=> !soft_start)
        else $error("soft start pulse too long");
    chk_blank_span: assert property (@(posedge clk) disable iff (rst)
        $rose(soft_start) |-> supply_age_q >= `CPS_TMR_W'(`CPS_POR_BLANK_CYC))
        else $error("soft start before blanking ended");
    chk_retry_span: assert property (@(posedge clk) disable iff (rst)
        $rose(pass_gate) |-> surge_age_q >= `CPS_TMR_W'(`CPS_OVP_RETRY_CYC))
        else $error("gate on before surge retry time");
    chk_oc_limit: assert property (@(posedge clk) disable iff (rst)
        (state_q == cps_pkg::CPS_ON && overcurrent && !reverse_sense) |=> current_limit_mode)
        else $error("current limit mode missing");
    chk_oc_span: assert property (@(posedge clk) disable iff (rst)
        $rose(state_q == cps_pkg::CPS_OC_RETRY) |-> oc_age_q >= `CPS_TMR_W'(`CPS_OCP_BLANK_CYC))
        else $error("over-current shutdown too early");
    chk_oc_hold: assert property (@(posedge clk) disable iff (rst)
        state_q == cps_pkg::CPS_OC_RETRY |-> !pass_gate)
        else $error("gate on during over-current retry");
    chk_cell_span: assert property (@(posedge clk) disable iff (rst)
        $rose(state_q == cps_pkg::CPS_CELL_OFF) |-> cell_age_q >= `CPS_TMR_W'(`CPS_BOVP_BLANK_CYC))
        else $error("cell surge shutdown too early");
    chk_cell_back: assert property (@(posedge clk) disable iff (rst)
        (state_q == cps_pkg::CPS_CELL_OFF && !cell_surge) |=> state_q != cps_pkg::CPS_CELL_OFF)
        else $error("no recovery after cell surge");
    chk_latch_count: assert property (@(posedge clk) disable iff (rst)
        $rose(latched_off) |-> fault_cnt_q == `CPS_CNT_W'(`CPS_LATCH_COUNT))
        else $error("latch set at wrong count");
    chk_latch_hold: assert property (@(posedge clk) disable iff (rst)
        state_q == cps_pkg::CPS_LATCHED |-> !pass_gate)
        else $error("gate on in latched state");
    chk_enable_clear: assert property (@(posedge clk) disable iff (rst)
        (!enable_n && !en_q && !(count_evt && !latch_q)) |=> !latched_off)
        else $error("enable edge did not clear latch");
    chk_fault_states: assert property (@(posedge clk) disable iff (rst)
        (state_q == cps_pkg::CPS_OC_RETRY || state_q == cps_pkg::CPS_CELL_OFF) |-> fault_n_oe)
        else $error("fault indication missing in shutdown");
    chk_gate_state: assert property (@(posedge clk) disable iff (rst)
        pass_gate |-> state_q == cps_pkg::CPS_ON)
        else $error("gate on outside on state");

    cov_gate_on: cover property (@(posedge clk) disable iff (rst) $rose(pass_gate));
    cov_oc_retry: cover property (@(posedge clk) disable iff (rst) state_q == cps_pkg::CPS_OC_RETRY);
    cov_cell_off: cover property (@(posedge clk) disable iff (rst) state_q == cps_pkg::CPS_CELL_OFF);
    cov_latched: cover property (@(posedge clk) disable iff (rst) $rose(latched_off));
    cov_released: cover property (@(posedge clk) disable iff (rst) $fell(latched_off));
endmodule
`default_nettype wire

// >>> testbench/cps_supply_host.sv
`timescale 1ns/1ps
`default_nettype none
// adapter supply and host pin; every change lands on a falling edge, away from sampling
module cps_supply_host (
    input wire logic clk,
    output logic supply_input_ok,
    output logic enable_n
);
    initial begin
        supply_input_ok = 1'b0;
        enable_n = 1'b0; // floating pin reads as enabled through the pull-down
    end
    task automatic power(input logic v);
        @(negedge clk);
        supply_input_ok = v;
    endtask
    task automatic enable(input logic on);
        @(negedge clk);
        enable_n = ~on; // high disables, low enables
    endtask
endmodule
`default_nettype wire

// >>> testbench/charger_protection_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((e) !== (g)) begin bad_count++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module charger_protection_sequencer_tb;
    logic clk, rst, input_surge, overcurrent, cell_surge, over_temp, current_limit_open, reverse_sense;
    logic supply_input_ok, enable_n, pass_gate, soft_start, current_limit_mode, reverse_pass_switch;
    logic fault_n_oe, latched_off;
    int bad_count = 0;
    int checks_done = 0;
    int n;
    int m;
    int faults = 0; // model: shutdowns counted toward the latch
    cps_supply_host i_cps_supply_host (.clk(clk), .supply_input_ok(supply_input_ok), .enable_n(enable_n));
    cps_sequencer i_cps_sequencer (.clk(clk), .rst(rst), .supply_input_ok(supply_input_ok),
        .input_surge(input_surge), .overcurrent(overcurrent), .cell_surge(cell_surge),
        .over_temp(over_temp), .current_limit_open(current_limit_open), .reverse_sense(reverse_sense),
        .enable_n(enable_n), .pass_gate(pass_gate), .soft_start(soft_start),
        .current_limit_mode(current_limit_mode), .reverse_pass_switch(reverse_pass_switch),
        .fault_n_oe(fault_n_oe), .latched_off(latched_off));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask
    // counts falling edges until the watched output takes v; capped so a hang cannot stall
    task automatic wait_on(input bit ss, input logic v, input int lim);
        n = 0;
        while (((ss ? soft_start : pass_gate) !== v) && n < lim) begin
            @(negedge clk);
            n++;
        end
    endtask
    // model gate: only the untimed blockers, so call it only where no interval is pending
    task automatic cmp(input string nm);
        `CHK(nm, !enable_n && faults < 16 && !over_temp && !current_limit_open && !input_surge, pass_gate)
        `CHK("latched", faults >= 16, latched_off)
    endtask
    task automatic tdone(input string nm);
        $display("test %s finished", nm);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        #30_000_000;
        bad_count++;
        $display("watchdog expired");
        results();
    end
    initial begin
        {input_surge, overcurrent, cell_surge, over_temp, current_limit_open, reverse_sense} = 6'h00;
        rst = 1'b1;
        n = int'($urandom(66));
        cyc(2);
        `CHK("gate_in_reset", 1'b0, pass_gate)
        rst = 1'b0;
        cyc(1);
        `CHK("fault_after_reset", 1'b0, fault_n_oe)
        // a blip shorter than the filter window must not start blanking
        i_cps_supply_host.power(1'b1);
        cyc(int'($urandom_range(900, 100)));
        i_cps_supply_host.power(1'b0);
        cyc(200);
        i_cps_supply_host.power(1'b1);
        wait_on(1'b1, 1'b1, 810000);
        `CHK("por_blank", 1'b1, n inside {[800995:801010]})
        cyc(1);
        cmp("gate_on");
        tdone("power_on");
        input_surge = 1'b1;
        cyc(1);
        `CHK("surge_fault", 1'b1, fault_n_oe)
        cmp("surge_off");
        input_surge = 1'b0;
        wait_on(1'b0, 1'b1, 810000);
        `CHK("surge_retry", 1'b1, n inside {[799990:800010]})
        tdone("input_surge");
        i_cps_supply_host.enable(1'b0);
        cyc(1);
        cmp("disabled");
        i_cps_supply_host.enable(1'b1);
        cyc(2);
        cmp("enabled");
        for (int f = 0; f < 2; f++) begin
            over_temp = (f == 0);
            current_limit_open = (f != 0);
            cyc(1);
            cmp("blocker_off");
            if (f == 0) `CHK("temp_no_fault", 1'b0, fault_n_oe)
            {over_temp, current_limit_open} = 2'h0;
            cyc(2);
            cmp("blocker_back");
        end
        tdone("blockers");
        // reverse flow must ignore over-current entirely
        reverse_sense = 1'b1;
        overcurrent = reverse_sense; // over-current arrives together with the reverse flow
        cyc(12000);
        `CHK("rev_switch", 1'b1, reverse_pass_switch)
        `CHK("rev_no_limit", 1'b0, current_limit_mode)
        cmp("rev_gate");
        reverse_sense = 1'b0;
        cyc(2);
        `CHK("rev_release", 1'b0, reverse_pass_switch)
        `CHK("oc_limit", 1'b1, current_limit_mode)
        wait_on(1'b0, 1'b0, 10100);
        `CHK("oc_blank", 1'b1, n inside {[9990:10002]})
        `CHK("oc_fault", 1'b1, fault_n_oe)
        overcurrent = 1'b0;
        faults++;
        wait_on(1'b0, 1'b1, 101000);
        `CHK("oc_retry", 1'b1, n inside {[99990:100005]})
        tdone("overcurrent");
        for (int k = 0; k < 15; k++) begin
            cell_surge = 1'b1;
            m = int'($urandom_range(17000, 16000));
            cyc(m);
            cmp("cell_blank");
            wait_on(1'b0, 1'b0, 2000);
            `CHK("cell_trip", 1'b1, n inside {[17595 - m:17606 - m]})
            `CHK("cell_fault", 1'b1, fault_n_oe)
            cell_surge = 1'b0;
            faults++;
            cyc(2);
            cmp("cell_back");
        end
        cyc(50);
        cmp("stays_latched");
        tdone("cell_surge");
        i_cps_supply_host.enable(1'b0);
        cyc(1);
        i_cps_supply_host.enable(1'b1);
        faults = 0;
        cyc(2);
        cmp("reenable");
        tdone("reenable");
        results();
    end
endmodule
`default_nettype wire
